// ### rtl/sfc_pkg.sv
package sfc_pkg;
	localparam int WORD_W = 24;
	localparam int TOC_W = 14;
	localparam int CNT_W = 15;
	// Select codes in the low nibble of each serial word
	localparam logic [3:0] SEL_FASTLOCK = 4'h_D;
	localparam logic [3:0] SEL_CTRL = 4'h_F;
	// Field positions
	localparam int SEL_LSB = 0;
	localparam int TOC_LSB = 4;
	localparam int CPF_LSB = 18;
	localparam int CSR_LSB = 22;
	localparam int PIZ_BIT = 4;
	localparam int AIZ_BIT = 5;
	localparam int PRST_BIT = 6;
	localparam int ARST_BIT = 7;
	localparam int PREDIV_BIT = 8;
	// Reset values and mode codes
	localparam logic [TOC_W-1:0] TOC_RST = 14'h_0000;
	localparam logic [TOC_W-1:0] TOC_HIZ = 14'h_0000;
	localparam logic [TOC_W-1:0] TOC_MANUAL = 14'h_0001;
	localparam logic [TOC_W-1:0] TOC_LOW = 14'h_0002;
	localparam logic [TOC_W-1:0] TOC_HIGH = 14'h_0003;
	localparam logic [TOC_W-1:0] TOC_TIMED_MIN = 14'h_0004;
	localparam logic [3:0] CPF_RST = 4'h_0;
	localparam logic [1:0] CSR_RST = 2'h_0;
	localparam logic [4:0] PUMP_STEADY = 5'h_01;
	localparam logic [1:0] LD_DIV_LAST = 2'h_3;
	// Counter reset stretch after power-up, in clk_sys cycles
	localparam int PU_RST_NS = 32;
	localparam int CLK_NS = 8;
	localparam logic [2:0] PU_RST_CYC = 3'((PU_RST_NS + CLK_NS - 1) / CLK_NS);

	typedef struct packed {
		logic [1:0] slip_reduction_factor;
		logic [3:0] cpf;
		logic [TOC_W-1:0] toc;
	} sfc_fl_cfg_t;

	typedef struct packed {
		logic ld_prediv;
		logic aux_rst;
		logic main_rst;
		logic aux_hiz;
		logic main_hiz;
	} sfc_ctl_t;

	// Mask of compare events skipped per sample under slip reduction
	function automatic logic [3:0] slip_mask(input logic [1:0] slip_reduction_factor);
		case (slip_reduction_factor)
			2'h_0: slip_mask = 4'h_0;
			2'h_1: slip_mask = 4'h_1;
			2'h_2: slip_mask = 4'h_3;
			default: slip_mask = 4'h_F;
		endcase
	endfunction

	function automatic logic is_timed(input logic [TOC_W-1:0] toc);
		is_timed = toc >= TOC_TIMED_MIN;
	endfunction
endpackage

// ### rtl/sfc_serial_rx.sv
`timescale 1ns/1ns
`default_nettype none
module sfc_serial_rx
	import sfc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	output logic word_vld,
	output logic [sfc_pkg::WORD_W-1:0] word
);
	import sfc_pkg::*;

	logic [1:0] clk_s, dat_s, le_s;
	logic clk_q, le_q;
	logic [WORD_W-1:0] shift_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clk_s <= 2'h_0;
			dat_s <= 2'h_0;
			le_s <= 2'h_0;
			clk_q <= 1'b0;
			le_q <= 1'b0;
		end else begin
			clk_s <= {clk_s[0], ser_clk};
			dat_s <= {dat_s[0], ser_data};
			le_s <= {le_s[0], ser_le};
			clk_q <= clk_s[1];
			le_q <= le_s[1];
		end
	end

	// Data goes in most significant bit first on each rising serial clock
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_r <= '0;
		end else if (clk_s[1] && !clk_q) begin
			shift_r <= {shift_r[WORD_W-2:0], dat_s[1]};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			word_vld <= 1'b0;
			word <= '0;
		end else begin
			word_vld <= le_s[1] && !le_q;
			if (le_s[1] && !le_q) begin
				word <= shift_r;
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/sfc_fl_timer.sv
`timescale 1ns/1ns
`default_nettype none
module sfc_fl_timer
	import sfc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic cmp_evt,
	input wire logic [sfc_pkg::TOC_W-1:0] toc,
	output logic active
);
	import sfc_pkg::*;

	logic [CNT_W-1:0] cnt_r;

	// Two comparison cycles per time-out unit
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
			active <= 1'b0;
		end else if (!is_timed(toc)) begin
			cnt_r <= '0;
			active <= 1'b0;
		end else if (start) begin
			cnt_r <= {toc, 1'b0};
			active <= 1'b1;
		end else if (active && cmp_evt) begin
			cnt_r <= cnt_r - 1'b1;
			active <= cnt_r != 15'h_0001;
		end
	end

	chk_timer_load: assert property (@(posedge clk_sys)
		disable iff (rst)
		start && is_timed(toc) |=> active && cnt_r == {$past(toc), 1'b0})
		else $error("timer load wrong");
	chk_timer_expire: assert property (@(posedge clk_sys)
		disable iff (rst)
		active && cmp_evt && cnt_r == 15'h_0001 && !start
		&& is_timed(toc) |=> !active)
		else $error("timer did not expire");
endmodule
`default_nettype wire

// ### rtl/sfc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module sfc_ctrl (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	input wire logic chip_en,
	input wire logic soft_pd,
	input wire logic main_cmp,
	input wire logic aux_cmp,
	output logic rf_fastlock_pin_o,
	output logic rf_fastlock_pin_oe,
	output logic fastlock_active,
	output logic [4:0] pump_multiple,
	output logic pd_sample,
	output logic ld_main_evt,
	output logic ld_aux_evt,
	output logic main_counter_reset,
	output logic aux_counter_reset,
	output logic main_pump_hiz,
	output logic aux_pump_hiz
);
	import sfc_pkg::*;

	logic word_vld;
	logic [WORD_W-1:0] word;
	sfc_fl_cfg_t cfg_r;
	sfc_ctl_t ctl_r;
	logic freq_wr;
	logic timed_act;
	logic [2:0] ce_s, mc_s, ac_s;
	logic main_evt, aux_evt;
	logic powered, powered_q;
	logic [2:0] pu_cnt_r;
	logic pu_rst;
	logic [3:0] slip_cnt_r;
	logic [1:0] ld_cnt_r;
	logic fl_nxt;

	// Select code match on a freshly latched word
	function automatic logic sel_hit(input logic vld,
		input logic [WORD_W-1:0] w, input logic [3:0] code);
		sel_hit = vld && w[SEL_LSB +: 4] == code;
	endfunction

	sfc_serial_rx u_rx (
		.clk_sys(clk_sys),
		.rst(rst),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_le(ser_le),
		.word_vld(word_vld),
		.word(word)
	);

	// Any even select code is taken as a frequency word
	assign freq_wr = word_vld && !word[SEL_LSB];

	sfc_fl_timer u_tmr (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(freq_wr),
		.cmp_evt(main_evt),
		.toc(cfg_r.toc),
		.active(timed_act)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cfg_r <= '{slip_reduction_factor: CSR_RST, cpf: CPF_RST, toc: TOC_RST};
		end else if (sel_hit(word_vld, word, SEL_FASTLOCK)) begin
			cfg_r.slip_reduction_factor <= word[CSR_LSB +: 2];
			cfg_r.cpf <= word[CPF_LSB +: 4];
			cfg_r.toc <= word[TOC_LSB +: TOC_W];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctl_r <= '0;
		end else if (sel_hit(word_vld, word, SEL_CTRL)) begin
			ctl_r.ld_prediv <= word[PREDIV_BIT];
			ctl_r.aux_rst <= word[ARST_BIT];
			ctl_r.main_rst <= word[PRST_BIT];
			ctl_r.aux_hiz <= word[AIZ_BIT];
			ctl_r.main_hiz <= word[PIZ_BIT];
		end
	end

	// Pins from the analog side pass two flops; the third is for edges
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ce_s <= 3'h_0;
			mc_s <= 3'h_0;
			ac_s <= 3'h_0;
		end else begin
			ce_s <= {ce_s[1:0], chip_en};
			mc_s <= {mc_s[1:0], main_cmp};
			ac_s <= {ac_s[1:0], aux_cmp};
		end
	end

	assign main_evt = mc_s[1] && !mc_s[2];
	assign aux_evt = ac_s[1] && !ac_s[2];
	assign powered = ce_s[1] && !soft_pd;

	// Stretch the power-up reset so the counters see several edges
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			powered_q <= 1'b0;
			pu_cnt_r <= 3'h_0;
		end else begin
			powered_q <= powered;
			if (powered && !powered_q) begin
				pu_cnt_r <= PU_RST_CYC;
			end else if (pu_cnt_r != 3'h_0) begin
				pu_cnt_r <= pu_cnt_r - 1'b1;
			end
		end
	end

	assign pu_rst = pu_cnt_r != 3'h_0;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			main_counter_reset <= 1'b0;
			aux_counter_reset <= 1'b0;
			main_pump_hiz <= 1'b0;
			aux_pump_hiz <= 1'b0;
		end else begin
			main_counter_reset <= ctl_r.main_rst || pu_rst;
			aux_counter_reset <= ctl_r.aux_rst || pu_rst;
			main_pump_hiz <= ctl_r.main_rst || ctl_r.main_hiz;
			aux_pump_hiz <= ctl_r.aux_rst || ctl_r.aux_hiz;
		end
	end

	assign fl_nxt = cfg_r.toc == TOC_MANUAL || timed_act;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fastlock_active <= 1'b0;
			pump_multiple <= PUMP_STEADY;
		end else begin
			fastlock_active <= fl_nxt;
			// Steady state is reported as 1X; the analog side scales it
			pump_multiple <= fl_nxt ? {1'b0, cfg_r.cpf} + 5'h_01
				: PUMP_STEADY;
		end
	end

	// Fastlock pulls the pin low; TOC_LOW and TOC_HIGH drive a fixed level; otherwise the pin floats
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rf_fastlock_pin_o <= 1'b0;
			rf_fastlock_pin_oe <= 1'b0;
		end else begin
			case (cfg_r.toc)
				TOC_HIZ: begin
					rf_fastlock_pin_o <= 1'b0;
					rf_fastlock_pin_oe <= 1'b0;
				end
				TOC_MANUAL, TOC_LOW: begin
					rf_fastlock_pin_o <= 1'b0;
					rf_fastlock_pin_oe <= 1'b1;
				end
				TOC_HIGH: begin
					rf_fastlock_pin_o <= 1'b1;
					rf_fastlock_pin_oe <= 1'b1;
				end
				default: begin
					rf_fastlock_pin_o <= 1'b0;
					rf_fastlock_pin_oe <= timed_act;
				end
			endcase
		end
	end

	// Dividers restart with the counters they shadow
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			slip_cnt_r <= 4'h_0;
			pd_sample <= 1'b0;
		end else if (main_counter_reset) begin
			slip_cnt_r <= 4'h_0;
			pd_sample <= 1'b0;
		end else begin
			pd_sample <= main_evt
				&& (slip_cnt_r & slip_mask(cfg_r.slip_reduction_factor)) == 4'h_0;
			if (main_evt) begin
				slip_cnt_r <= slip_cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ld_cnt_r <= 2'h_0;
			ld_main_evt <= 1'b0;
		end else if (main_counter_reset) begin
			ld_cnt_r <= 2'h_0;
			ld_main_evt <= 1'b0;
		end else begin
			ld_main_evt <= main_evt
				&& (!ctl_r.ld_prediv || ld_cnt_r == LD_DIV_LAST);
			if (main_evt) begin
				ld_cnt_r <= ld_cnt_r + 1'b1;
			end
		end
	end

	// Auxiliary comparison path is never divided
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ld_aux_evt <= 1'b0;
		end else begin
			ld_aux_evt <= aux_evt && !aux_counter_reset;
		end
	end

	chk_pin_float_off: assert property (@(posedge clk_sys)
		disable iff (rst)
		$past(cfg_r.toc) == TOC_HIZ |-> !rf_fastlock_pin_oe)
		else $error("pin driven while floating");
	chk_pin_static_level: assert property (@(posedge clk_sys)
		disable iff (rst)
		$past(cfg_r.toc) == TOC_HIGH || $past(cfg_r.toc) == TOC_LOW
		|-> rf_fastlock_pin_oe
		&& rf_fastlock_pin_o == ($past(cfg_r.toc) == TOC_HIGH))
		else $error("static pin level wrong");
	chk_manual_forces: assert property (@(posedge clk_sys)
		disable iff (rst)
		cfg_r.toc == TOC_MANUAL |=> fastlock_active && rf_fastlock_pin_oe
		&& !rf_fastlock_pin_o)
		else $error("manual fastlock not forced");
	chk_timed_pin: assert property (@(posedge clk_sys)
		disable iff (rst)
		is_timed($past(cfg_r.toc))
		|-> rf_fastlock_pin_oe == fastlock_active && !rf_fastlock_pin_o)
		else $error("timed pin not following fastlock");
	chk_timed_idle: assert property (@(posedge clk_sys)
		disable iff (rst)
		is_timed(cfg_r.toc) && !timed_act |=> !rf_fastlock_pin_oe)
		else $error("timed pin driven before start");
	chk_timed_start: assert property (@(posedge clk_sys)
		disable iff (rst)
		freq_wr && is_timed(cfg_r.toc) && !(word[3:0] == SEL_FASTLOCK)
		|=> ##1 fastlock_active)
		else $error("fastlock did not start");
	chk_word_fields: assert property (@(posedge clk_sys)
		disable iff (rst)
		sel_hit(word_vld, word, SEL_FASTLOCK)
		|=> cfg_r == word[WORD_W-1:TOC_LSB])
		else $error("fastlock word fields misplaced");
	chk_pump_mult: assert property (@(posedge clk_sys)
		disable iff (rst)
		fastlock_active |-> pump_multiple == {1'b0, $past(cfg_r.cpf)} + 5'h_01)
		else $error("pump multiple wrong");
	chk_pump_steady: assert property (@(posedge clk_sys)
		disable iff (rst)
		!fastlock_active |-> pump_multiple == PUMP_STEADY)
		else $error("steady pump multiple wrong");
	chk_slip_off: assert property (@(posedge clk_sys)
		disable iff (rst)
		main_evt && cfg_r.slip_reduction_factor == 2'h_0 && !main_counter_reset |=> pd_sample)
		else $error("sample lost with slip off");
	chk_slip_sparse: assert property (@(posedge clk_sys)
		disable iff (rst)
		pd_sample && $past(cfg_r.slip_reduction_factor) == 2'h_3 |-> ##1 !pd_sample[*8])
		else $error("slip reduction too dense");
	chk_ld_undivided: assert property (@(posedge clk_sys)
		disable iff (rst)
		main_evt && !ctl_r.ld_prediv && !main_counter_reset |=> ld_main_evt)
		else $error("lock detect event lost");
	chk_ld_divided: assert property (@(posedge clk_sys)
		disable iff (rst)
		main_evt && ctl_r.ld_prediv && ld_cnt_r != LD_DIV_LAST |=> !ld_main_evt)
		else $error("lock detect not divided");
	chk_aux_undivided: assert property (@(posedge clk_sys)
		disable iff (rst)
		aux_evt && !aux_counter_reset |=> ld_aux_evt)
		else $error("aux lock detect event lost");
	chk_counter_reset: assert property (@(posedge clk_sys)
		disable iff (rst)
		ctl_r.main_rst |=> main_counter_reset && main_pump_hiz)
		else $error("main counter reset not applied");
	chk_aux_reset: assert property (@(posedge clk_sys)
		disable iff (rst)
		ctl_r.aux_rst |=> aux_counter_reset && aux_pump_hiz)
		else $error("aux counter reset not applied");
	chk_powerup_reset: assert property (@(posedge clk_sys)
		disable iff (rst)
		powered && !powered_q |=> ##1 main_counter_reset[*4])
		else $error("power-up reset missing");
	chk_hiz_no_reset: assert property (@(posedge clk_sys)
		disable iff (rst)
		ctl_r.main_hiz && !ctl_r.main_rst && !pu_rst
		|=> main_pump_hiz && !main_counter_reset)
		else $error("hiz reset the counters");
	chk_hiz_release: assert property (@(posedge clk_sys)
		disable iff (rst)
		!ctl_r.main_rst && !ctl_r.main_hiz |=> !main_pump_hiz)
		else $error("main pump floated without cause");
	chk_aux_hiz: assert property (@(posedge clk_sys)
		disable iff (rst)
		ctl_r.aux_hiz && !ctl_r.aux_rst && !pu_rst
		|=> aux_pump_hiz && !aux_counter_reset)
		else $error("aux hiz reset the counters");
endmodule
`default_nettype wire

// ### dv/sfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfc_host_model (
	input wire logic clk_sys,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_le
);
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		ser_le = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Phases of at least two cycles keep the serial clock legal at any pace
	task automatic write_word(input logic [23:0] w, input int slow);
		int i;
		step(1);
		for (i = 23; i >= 0; i--) begin
			ser_data = w[i];
			step(2 + slow);
			ser_clk = 1'b1;
			step(2 + slow);
			ser_clk = 1'b0;
		end
		// Data line is not left showing the last bit between frames
		ser_data = ~w[0];
		step(2);
		ser_le = 1'b1;
		step(3);
		ser_le = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### dv/sfc_ctrl_bench.sv
`timescale 1ns/1ns
`default_nettype none
module sfc_ctrl_bench;
	import sfc_pkg::*;
	typedef struct packed {
		logic [11:0] lv;
		logic [23:0] cnt;
	} sfc_note_t;
	logic clk_sys, rst, ser_clk, ser_data, ser_le, chip_en, soft_pd;
	logic main_cmp, aux_cmp, pin_o, pin_oe, fl_act, pd_sample;
	logic ld_main_evt, ld_aux_evt, main_rst, aux_rst, main_hiz, aux_hiz;
	logic [4:0] pump_mult;
	logic [4:0] b;
	logic [3:0] r;
	logic take;
	logic [15:0] seed;
	logic [7:0] n_pd, n_lm, n_la;
	int mismatches, check_count, cycles, i, k;
	sfc_note_t notes[$];
	sfc_note_t got, want;
	logic [4:0] ctl_tab [6] = '{5'h_01, 5'h_02, 5'h_04, 5'h_08, 5'h_10,
		5'h_00};

	always #4 clk_sys = ~clk_sys;

	sfc_host_model host (.clk_sys(clk_sys), .ser_clk(ser_clk),
		.ser_data(ser_data), .ser_le(ser_le));

	sfc_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .ser_clk(ser_clk),
		.ser_data(ser_data), .ser_le(ser_le), .chip_en(chip_en),
		.soft_pd(soft_pd), .main_cmp(main_cmp), .aux_cmp(aux_cmp),
		.rf_fastlock_pin_o(pin_o), .rf_fastlock_pin_oe(pin_oe),
		.fastlock_active(fl_act), .pump_multiple(pump_mult),
		.pd_sample(pd_sample), .ld_main_evt(ld_main_evt),
		.ld_aux_evt(ld_aux_evt), .main_counter_reset(main_rst),
		.aux_counter_reset(aux_rst), .main_pump_hiz(main_hiz),
		.aux_pump_hiz(aux_hiz));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		lfsr = {1'b0, s[15:1]} ^ (s[0] ? 16'h_B400 : 16'h_0000);
	endfunction

	function automatic logic [11:0] lvl(input logic oe, input logic o,
		input logic act, input logic [3:0] cpf, input logic [3:0] ctl);
		lvl = {oe, o, act, act ? {1'b0, cpf} + 5'h_01 : 5'h_01, ctl};
	endfunction

	task automatic complete_run();
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp_lvl(input logic [11:0] g, input logic [11:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected level at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_cnt(input logic [23:0] g, input logic [23:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected count at %0t: got %h exp %h", $time, g, e);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic expect_now(input logic [11:0] lv, input logic [7:0] pd,
		input logic [7:0] lm, input logic [7:0] la);
		notes.push_back({lv, pd, lm, la});
		take = 1'b1;
		step(1);
		take = 1'b0;
	endtask

	task automatic pulses(input int n, input logic m, input logic a);
		repeat (n) begin
			main_cmp = m;
			aux_cmp = a;
			step(3);
			main_cmp = 1'b0;
			aux_cmp = 1'b0;
			step(5);
		end
		step(6);
	endtask

	task automatic wr(input logic [23:0] w);
		seed = lfsr(seed);
		host.write_word(w, int'(seed[1:0]));
		step(8);
	endtask

	// Pulses are tallied between two notes, then judged with the levels
	always @(posedge clk_sys) begin
		cycles++;
		n_pd = n_pd + 8'(pd_sample === 1'b1);
		n_lm = n_lm + 8'(ld_main_evt === 1'b1);
		n_la = n_la + 8'(ld_aux_evt === 1'b1);
		if (take) begin
			want = notes.pop_front();
			got = {pin_oe, pin_o, fl_act, pump_mult, main_rst, aux_rst,
				main_hiz, aux_hiz, n_pd, n_lm, n_la};
			cmp_lvl(got.lv, want.lv);
			cmp_cnt(got.cnt, want.cnt);
			n_pd = 8'h_00;
			n_lm = 8'h_00;
			n_la = 8'h_00;
		end
		if (cycles == 40000) begin
			mismatches++;
			complete_run();
		end
	end

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		chip_en = 1'b0;
		soft_pd = 1'b0;
		main_cmp = 1'b0;
		aux_cmp = 1'b0;
		take = 1'b0;
		seed = 16'h_4CAE;
		mismatches = 0;
		check_count = 0;
		cycles = 0;
		n_pd = 8'h_00;
		n_lm = 8'h_00;
		n_la = 8'h_00;
		step(3);
		rst = 1'b0;
		step(4);
		expect_now(lvl(0, 0, 0, 0, 4'h_0), 0, 0, 0);
		// First power-up by the enable pin, then by software
		for (i = 0; i < 2; i++) begin
			soft_pd = 1'(i);
			step(8);
			chip_en = 1'b1;
			soft_pd = 1'b0;
			k = 0;
			while (main_rst !== 1'b1 && k < 10) begin
				step(1);
				k++;
			end
			// Automatic reset holds the counters but leaves the pumps driven
			expect_now(lvl(0, 0, 0, 0, 4'h_C), 0, 0, 0);
			step(8);
			expect_now(lvl(0, 0, 0, 0, 4'h_0), 0, 0, 0);
		end
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			r = seed[3:0];
			wr({2'h_0, r, 14'(i), 4'h_D});
			expect_now(lvl(i != 0, i == 3, i == 1, r, 4'h_0), 0, 0, 0);
		end
		for (i = 4; i < 6; i++) begin
			seed = lfsr(seed);
			r = seed[3:0];
			wr({2'h_0, r, 14'(i), 4'h_D});
			expect_now(lvl(0, 0, 0, r, 4'h_0), 0, 0, 0);
			seed = lfsr(seed);
			// Any even select code is a frequency word and starts the count
			wr({seed, seed[7:4], seed[3:1], 1'b0});
			expect_now(lvl(1, 0, 1, r, 4'h_0), 0, 0, 0);
			pulses(2 * i - 1, 1'b1, 1'b0);
			expect_now(lvl(1, 0, 1, r, 4'h_0), 8'(2 * i - 1),
				8'(2 * i - 1), 0);
			pulses(1, 1'b1, 1'b0);
			expect_now(lvl(0, 0, 0, r, 4'h_0), 1, 1, 0);
		end
		seed = lfsr(seed);
		wr({seed, 4'h_0, 4'h_B});
		expect_now(lvl(0, 0, 0, 0, 4'h_0), 0, 0, 0);
		for (i = 0; i < 4; i++) begin
			wr({2'(i), 4'h_0, 14'h_0002, 4'h_D});
			pulses(32, 1'b1, 1'b1);
			expect_now(lvl(1, 0, 0, 0, 4'h_0), 8'(32 >> (i == 3 ? 4 : i)),
				32, 32);
		end
		wr({2'h_0, 4'h_0, 14'h_0002, 4'h_D});
		for (i = 0; i < 6; i++) begin
			b = ctl_tab[i];
			wr({15'h_0000, b, 4'h_F});
			pulses(32, ~b[2], 1'b1);
			expect_now(lvl(1, 0, 0, 0, {b[2], b[3], b[0] | b[2], b[1] | b[3]}),
				b[2] ? 8'h_00 : 8'h_20,
				b[2] ? 8'h_00 : (b[4] ? 8'h_08 : 8'h_20),
				b[3] ? 8'h_00 : 8'h_20);
		end
		complete_run();
	end
endmodule
`default_nettype wire
